//--- bench/ocdc_host.sv
/*
 Debug host model on the single wire: sends and receives 8N1 bytes.
 Assumes the wire has a pull-up and the bench resolves its level.
*/
`timescale 1ns/100ps
module ocdc_host
   import ocdc_pkg::*;
#(parameter int BIT = 16)
(
   input wire logic clk, // Clock
   input wire logic line, // Wire level
   input wire logic dut_oe, // Device drives
   output logic h_out, // Drive value
   output logic h_oe, // Drive enable
   output logic rx_vld, // Byte seen
   output logic [7:0] rx_data // Byte value
);
   initial begin
      {h_out, h_oe, rx_vld, rx_data} = 11'h400;
   end
   task automatic drive(input logic v);
      @(negedge clk);
      h_oe = 1'b1;
      h_out = v;
   endtask
   task automatic let_go();
      h_oe = 1'b0;
      h_out = 1'b1;
   endtask
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      wait (dut_oe === 1'b0);
      for (int i = 0; i < 10; i++) begin
         drive(f[i]);
         repeat (BIT - 1) @(negedge clk);
      end
      @(negedge clk);
      let_go();
   endtask
   task automatic key(input logic [31:0] k);
      for (int i = 31; i >= 0; i--) begin
         h_oe = 1'b1;
         h_out = k[i];
         @(negedge clk);
      end
      let_go();
   endtask
   // ------------------------------------------
   // Receiver, mid-bit sampling
   // ------------------------------------------
   always begin
      @(negedge clk);
      if (dut_oe === 1'b1 && line === 1'b0) begin
         repeat (BIT / 2) @(negedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(negedge clk);
            rx_data[i] = line;
         end
         rx_vld = 1'b1;
         @(negedge clk);
         rx_vld = 1'b0;
         repeat (BIT) @(negedge clk);
      end
   end
endmodule

//--- bench/ocdc_top_assertions.sv
/*
 Checker on the debug controller top ports.
 Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/100ps
module ocdc_top_assertions
   import ocdc_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic nrst, // Reset, low
   input wire logic shared_debug_pin_in, // Wire level
   input wire logic cpu_halted, // Halt
   input wire logic cpu_brk_exec, // Break run
   input wire logic stop_mode, // Sleep
   input wire logic wdt_enabled, // Watchdog on
   input wire logic read_protect, // Protect
   input wire logic ctl_debug_set, // Enter
   input wire logic ctl_brk_en, // Break enable
   input wire logic shared_debug_pin_oe, // Drive
   input wire logic cpu_fetch_stop, // Fetch stop
   input wire logic cpu_halt_exit, // Halt exit
   input wire logic cpu_step, // Step
   input wire logic cpu_stuff_vld, // Stuff
   input wire logic wdt_refresh, // Refresh
   input wire logic brk_enabled, // Break on
   input wire logic debug_mode // Debug
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ------------------------------------------
   // Port relations
   // ------------------------------------------
   AST_FETCH: assert property ($rose(debug_mode) |-> ##[0:1] cpu_fetch_stop)
      else $error("fetch not stopped");
   AST_WAKE: assert property ($rose(debug_mode && cpu_halted) |-> ##[0:2] cpu_halt_exit)
      else $error("halt not left");
   AST_WDT: assert property ((debug_mode && wdt_enabled && !stop_mode) [*2] |-> wdt_refresh)
      else $error("watchdog not refreshed");
   AST_STOP: assert property (stop_mode |=> !wdt_refresh)
      else $error("refresh in sleep");
   AST_BRK: assert property (cpu_brk_exec && brk_enabled |-> ##[1:2] debug_mode)
      else $error("no entry on break");
   AST_STEP: assert property (cpu_step |-> debug_mode && !read_protect)
      else $error("step not allowed");
   AST_STUFF: assert property (cpu_stuff_vld |-> debug_mode && !read_protect)
      else $error("stuff not allowed");
   AST_CTL: assert property (brk_enabled == $past(ctl_brk_en))
      else $error("break enable lag wrong");
   AST_SET: assert property (ctl_debug_set |-> ##1 debug_mode)
      else $error("no entry on set");
   AST_TURN: assert property ($rose(shared_debug_pin_oe) |-> $past(shared_debug_pin_in))
      else $error("drive over busy wire");
endmodule
bind ocdc_top ocdc_top_assertions u_chk (.clk(clk), .nrst(nrst), .cpu_halted(cpu_halted),
   .shared_debug_pin_in(shared_debug_pin_in), .cpu_brk_exec(cpu_brk_exec),
   .stop_mode(stop_mode), .wdt_enabled(wdt_enabled), .read_protect(read_protect),
   .ctl_debug_set(ctl_debug_set), .ctl_brk_en(ctl_brk_en), .cpu_step(cpu_step),
   .shared_debug_pin_oe(shared_debug_pin_oe), .cpu_fetch_stop(cpu_fetch_stop),
   .cpu_halt_exit(cpu_halt_exit), .cpu_stuff_vld(cpu_stuff_vld),
   .wdt_refresh(wdt_refresh), .brk_enabled(brk_enabled), .debug_mode(debug_mode));

//--- bench/ocdc_top_test.sv
/*
 Self-checking bench for the debug controller top.
 Assumes the host model and a combinational program memory pattern.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
   $display("mismatch at %0t got %h exp %h", $time, a, e); end end
module ocdc_top_test
   import ocdc_pkg::*;
;
   logic clk, nrst, sys_rst_n, rpin, breakpoint_instruction, halted, idone, stop, wdt, rp, dset, dclr, brken;
   logic rreq, live, h_out, h_oe, h_vld, pin_out, pin_oe, fetch, hexit, step, svld, sfirst;
   logic refresh, brk_on, dev_rst, unlocked, dmode, rd;
   logic [7:0] h_data, sbyte, b;
   logic [PM_AW-1:0] addr;
   logic [11:0] q[$];
   int fail_count = 0;
   int cmp_count = 0;
   logic [7:0] ops[4] = '{8'h0f, 8'h52, 8'h56, 8'h58};
   wire line = pin_oe ? pin_out : (h_oe ? h_out : 1'b1);
   wire [7:0] rdata = addr[7:0] ^ {addr[10:8], 5'h00};
   ocdc_top DUT (.clk(clk), .nrst(nrst), .sys_rst_n(sys_rst_n), .shared_reset_pin_in(rpin),
      .shared_debug_pin_in(line), .cpu_brk_exec(breakpoint_instruction), .cpu_halted(halted),
      .cpu_instr_done(idone), .stop_mode(stop), .wdt_enabled(wdt), .read_protect(rp),
      .ctl_debug_set(dset), .ctl_debug_clr(dclr), .ctl_brk_en(brken), .ctl_reset_req(rreq),
      .pm_rdata(rdata), .shared_debug_pin_out(pin_out), .shared_debug_pin_oe(pin_oe),
      .pm_addr(addr), .pm_rd(rd), .cpu_fetch_stop(fetch), .cpu_halt_exit(hexit),
      .cpu_step(step), .cpu_stuff_vld(svld), .cpu_stuff_byte(sbyte), .cpu_stuff_first(sfirst),
      .wdt_refresh(refresh), .brk_enabled(brk_on), .device_reset_req(dev_rst),
      .debug_unlocked(unlocked), .debug_mode(dmode));
   ocdc_host #(.BIT(16)) H (.clk(clk), .line(line), .dut_oe(pin_oe), .h_out(h_out),
      .h_oe(h_oe), .rx_vld(h_vld), .rx_data(h_data));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ------------------------------------------
   // Helpers
   // ------------------------------------------
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic got(input logic [11:0] v);
      logic [11:0] e;
      e = (q.size() > 0) ? q.pop_front() : 12'hfff;
      `CHK(v, e)
   endtask
   task automatic wait_q();
      for (int i = 0; i < 9000 && q.size() > 0; i++) @(negedge clk);
      repeat (3) @(negedge clk);
      idone = 1'b1;
      @(negedge clk);
      idone = 1'b0;
   endtask
   task automatic crc_cmd(input logic [15:0] v);
      q.push_back({4'h2, v[15:8]});
      q.push_back({4'h2, v[7:0]});
      H.send(CMD_CRC);
      repeat (4) @(negedge clk);
      `CHK(rd, dmode)
      wait_q();
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   function automatic logic [15:0] crc_exp();
      logic [15:0] c;
      logic [10:0] m;
      c = CRC_SEED;
      for (int a = 0; a < 2048; a++) begin
         m = a[10:0];
         c ^= {m[7:0] ^ {m[10:8], 5'h00}, 8'h00};
         for (int k = 0; k < 8; k++) c = c[15] ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
      end
      return c;
   endfunction
   always @(posedge clk) begin
      if (live && h_vld === 1'b1) got({4'h2, h_data});
   end
   always @(negedge clk) begin
      if (step === 1'b1) got(12'h400);
      if (step === 1'b1) `CHK(fetch, 1'b0)
      if (svld === 1'b1) got({3'h1, sfirst, sbyte});
   end
   initial begin
      #1500000;
      fail_count++;
      give_verdict();
   end
   // ------------------------------------------
   // Tests
   // ------------------------------------------
   initial begin
      {nrst, sys_rst_n, breakpoint_instruction, halted, idone, stop, wdt, rp, dset, dclr, brken, rreq} = '0;
      {rpin, live} = 2'b10;
      void'($urandom(96));
      repeat (4) @(negedge clk);
      `CHK({pin_out, pin_oe, dmode, unlocked}, 4'h8)
      nrst = 1'b1;
      @(negedge clk);
      rpin = 1'b0;
      H.key(KEY_VALUE);
      rpin = 1'b1;
      repeat (3) @(negedge clk);
      `CHK(unlocked, 1'b1)
      H.drive(1'b0);
      repeat (2) @(negedge clk);
      sys_rst_n = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(dmode, 1'b1)
      repeat (5000) @(negedge clk);
      H.let_go();
      nrst = 1'b0;
      @(negedge clk);
      nrst = 1'b1;
      live = 1'b1;
      `CHK(dmode, 1'b0)
      $display("test entry and key done");
      H.send(8'h80);
      crc_cmd(CRC_OFF_VALUE);
      H.send(CMD_STEP);
      H.send(CMD_STUFF);
      H.send(CMD_STEP);
      H.send(CMD_EXEC);
      H.send(CMD_STEP);
      crc_cmd(CRC_OFF_VALUE);
      $display("test outside debug done");
      halted = 1'b1;
      wdt = 1'b1;
      pulse(dset);
      halted = 1'b0;
      `CHK({dmode, fetch, refresh}, 3'h7)
      stop = 1'b1;
      @(negedge clk);
      `CHK(refresh, 1'b0)
      stop = 1'b0;
      crc_cmd(crc_exp());
      q.push_back(12'h400);
      H.send(CMD_STEP);
      wait_q();
      b = 8'($urandom());
      q.push_back({4'h3, b});
      H.send(CMD_STUFF);
      H.send(b);
      wait_q();
      for (int i = 0; i < 4; i++) begin
         q.push_back({4'h2, ops[i]});
         H.send(CMD_EXEC);
         H.send(ops[i]);
         for (int j = 0; j < i; j++) begin
            b = 8'($urandom());
            q.push_back({4'h2, b});
            H.send(b);
         end
         wait_q();
      end
      rp = 1'b1;
      H.send(CMD_STEP);
      H.send(CMD_STUFF);
      H.send(CMD_STEP);
      H.send(CMD_EXEC);
      H.send(CMD_STEP);
      rp = 1'b0;
      q.push_back(12'h400);
      H.send(CMD_STEP);
      wait_q();
      $display("test debug commands done");
      pulse(dclr);
      `CHK(dmode, 1'b0)
      brken = 1'b1;
      rreq = 1'b1;
      pulse(breakpoint_instruction);
      `CHK({dmode, brk_on, dev_rst}, 3'h7)
      rreq = 1'b0;
      $display("test break done");
      `CHK(q.size(), 0)
      give_verdict();
   end
endmodule

//--- rtl/ocdc_crc.sv
/*
 Serial checksum engine: CRC-CCITT over the whole program memory,
 one byte per clock. Assumes a combinational memory read port.
*/
`timescale 1ns/100ps
module ocdc_crc
   import ocdc_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic nrst, // Async reset, low
   input wire logic start, // Begin a pass
   input wire logic [7:0] pm_data, // Memory byte
   output logic [PM_AW-1:0] pm_addr, // Memory address
   output logic busy, // Pass running
   output logic done, // Pass finished pulse
   output logic [15:0] crc // Result
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [PM_AW-1:0] addr;
      logic [15:0] crc;
   } ocdc_crc_st_t;

   ocdc_crc_st_t s_q, s_d;

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {b, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (start && !s_q.busy) begin
         s_d.busy = 1'b1;
         s_d.addr = PM_ZERO;
         s_d.crc = CRC_SEED;
      end else if (s_q.busy) begin
         s_d.crc = crc_byte(s_q.crc, pm_data);
         s_d.addr = s_q.addr + 1'b1;
         if (s_q.addr == PM_LAST) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pm_addr = s_q.addr;
   assign busy = s_q.busy;
   assign done = s_q.done;
   assign crc = s_q.crc;
endmodule

//--- rtl/ocdc_pkg.sv
/*
 Package for the on-chip debug controller: command codes, timing counts,
 link framing, program memory size and checksum constants.
 Assumes a 40 MHz system clock.
*/
package ocdc_pkg;
   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int CLK_PERIOD_NS = 25;
   // ---------------------------------------------------------------
   // Debug commands
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_CRC = 8'h0e;
   localparam logic [7:0] CMD_STEP = 8'h10;
   localparam logic [7:0] CMD_STUFF = 8'h11;
   localparam logic [7:0] CMD_EXEC = 8'h12;
   localparam logic [7:0] OP_BREAK = 8'h00;
   // ---------------------------------------------------------------
   // Checksum
   // ---------------------------------------------------------------
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_SEED = 16'hffff;
   localparam logic [15:0] CRC_OFF_VALUE = 16'hffff;
   // ---------------------------------------------------------------
   // Program memory and key
   // ---------------------------------------------------------------
   localparam int PM_AW = 11;
   localparam logic [PM_AW-1:0] PM_LAST = 11'h7ff;
   localparam logic [PM_AW-1:0] PM_ZERO = 11'h000;
   localparam int KEY_BITS = 32;
   localparam logic [31:0] KEY_VALUE = 32'h5a3c_96e1; // Arbitrary value
   // ---------------------------------------------------------------
   // Serial link framing
   // ---------------------------------------------------------------
   localparam int BAUD_W = 16;
   localparam logic [BAUD_W-1:0] BAUD_ONE = 16'h0001;
   localparam logic [BAUD_W-1:0] BAUD_ZERO = 16'h0000;
   localparam logic [3:0] BITS_FRAME = 4'h9;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   localparam logic [2:0] LEN_ONE = 3'h1;
   localparam logic [2:0] LEN_ZERO = 3'h0;
   localparam logic [5:0] KEY_CNT_ZERO = 6'h00;
   localparam logic [5:0] KEY_CNT_FULL = 6'h20;
   // Autobaud: the host sends 80h, start plus seven zero bits is 8 bit times
   localparam int AUTOBAUD_SHIFT = 3;

   // Instruction length from opcode, used by execute command
   function automatic logic [2:0] ocdc_op_len(input logic [7:0] op);
      logic [2:0] len;
      len = 3'h2;
      if (op[3:0] == 4'hf || op == OP_BREAK) begin
         len = 3'h1;
      end else if (op[3:0] == 4'h4 || op[3:0] == 4'h5 || op[3:0] == 4'h6 ||
                   op[3:0] == 4'h7) begin
         len = 3'h3;
      end else if (op[3:0] == 4'h8 || op[3:0] == 4'h9) begin
         len = 3'h4;
      end
      return len;
   endfunction
endpackage

//--- rtl/ocdc_top.sv
/*
 On-chip debug controller top: debug mode, unlock key, command handling.
 Assumes a CPU with fetch stop, halt exit, one-instruction run ports,
 and a program memory read port shared with the checksum engine.
*/
`timescale 1ns/100ps
module ocdc_top
   import ocdc_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic nrst, // Async reset, low
   input wire logic sys_rst_n, // System reset level, low
   input wire logic shared_reset_pin_in, // Shared reset pin level
   input wire logic shared_debug_pin_in, // Debug wire level
   input wire logic cpu_brk_exec, // CPU executed breakpoint
   input wire logic cpu_halted, // CPU in halt state
   input wire logic cpu_instr_done, // Directed instruction done
   input wire logic stop_mode, // Deep sleep active
   input wire logic wdt_enabled, // Watchdog enabled
   input wire logic read_protect, // Flash read protection
   input wire logic ctl_debug_set, // Request debug entry
   input wire logic ctl_debug_clr, // Request debug exit
   input wire logic ctl_brk_en, // Breakpoint enable
   input wire logic ctl_reset_req, // Request full reset
   input wire logic [7:0] pm_rdata, // Program memory data
   output logic shared_debug_pin_out, // Debug wire drive value
   output logic shared_debug_pin_oe, // Debug wire drive enable
   output logic [PM_AW-1:0] pm_addr, // Program memory address
   output logic pm_rd, // Program memory read
   output logic cpu_fetch_stop, // Stop CPU fetch
   output logic cpu_halt_exit, // Leave halt pulse
   output logic cpu_step, // Run one instruction pulse
   output logic cpu_stuff_vld, // Injected byte valid pulse
   output logic [7:0] cpu_stuff_byte, // Injected byte
   output logic cpu_stuff_first, // Injected byte is first only
   output logic wdt_refresh, // Watchdog refresh
   output logic brk_enabled, // Breakpoint enabled
   output logic device_reset_req, // Full device reset
   output logic debug_unlocked, // Debug feature unlocked
   output logic debug_mode // In debug mode
);
   typedef enum logic [2:0] {
      C_CMD, C_STUFF_OP, C_EXEC_BYTES, C_DISCARD, C_CRC_WAIT, C_TX_HI, C_TX_LO, C_RUN
   } ocdc_cmd_t;

   typedef struct packed {
      ocdc_cmd_t st;
      logic dbg;
      logic brk_en;
      logic unlocked;
      logic [31:0] key;
      logic [5:0] key_cnt;
      logic key_prev;
      logic rst_prev;
      logic pin_prev;
      logic [2:0] left;
      logic first;
      logic [15:0] crc;
      logic tx_go;
      logic [7:0] tx_byte;
      logic fetch_stop;
      logic halt_exit;
      logic step;
      logic stuff_vld;
      logic [7:0] stuff_byte;
      logic stuff_first;
      logic wdt;
      logic dev_rst;
      logic pm_rd;
      logic pin_out;
      logic pin_oe;
      logic crc_start;
   } ocdc_st_t;

   ocdc_st_t s_q, s_d;
   logic rx_valid;
   logic [7:0] rx_byte;
   logic tx_busy;
   logic tx_out;
   logic tx_oe;
   logic crc_busy;
   logic crc_done;
   logic [15:0] crc_val;
   logic [PM_AW-1:0] crc_addr;

   // ---------------------------------------------------------------
   // Serial link and checksum engines
   // ---------------------------------------------------------------
   ocdc_uart u_uart (
      .clk(clk),
      .nrst(nrst),
      .rx_in(shared_debug_pin_in),
      .tx_go(s_q.tx_go),
      .tx_byte(s_q.tx_byte),
      .rx_valid(rx_valid),
      .rx_byte(rx_byte),
      .tx_busy(tx_busy),
      .tx_out(tx_out),
      .tx_oe(tx_oe),
      .locked()
   );

   ocdc_crc u_crc (
      .clk(clk),
      .nrst(nrst),
      .start(s_q.crc_start),
      .pm_data(pm_rdata),
      .pm_addr(crc_addr),
      .busy(crc_busy),
      .done(crc_done),
      .crc(crc_val)
   );

   function automatic logic cmd_ok(input logic dbg, input logic prot);
      return dbg && !prot;
   endfunction

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.tx_go = 1'b0;
      s_d.halt_exit = 1'b0;
      s_d.step = 1'b0;
      s_d.stuff_vld = 1'b0;
      s_d.crc_start = 1'b0;
      s_d.rst_prev = sys_rst_n;
      s_d.pin_prev = shared_debug_pin_in;
      s_d.key_prev = shared_reset_pin_in;
      s_d.brk_en = ctl_brk_en;
      s_d.dev_rst = ctl_reset_req;
      if (!s_q.rst_prev && sys_rst_n && !s_q.pin_prev) begin
         s_d.dbg = 1'b1;
      end
      if (!shared_reset_pin_in) begin
         if (s_q.key_cnt != KEY_CNT_FULL) begin
            s_d.key = {s_q.key[30:0], shared_debug_pin_in};
            s_d.key_cnt = s_q.key_cnt + 1'b1;
         end
      end else begin
         s_d.key_cnt = KEY_CNT_ZERO;
         if (!s_q.key_prev && s_q.key_cnt == KEY_CNT_FULL && s_q.key == KEY_VALUE) begin
            s_d.unlocked = 1'b1;
         end
      end
      if (cpu_brk_exec && s_q.brk_en) begin
         s_d.dbg = 1'b1;
      end
      if (ctl_debug_set) begin
         s_d.dbg = 1'b1;
      end else if (ctl_debug_clr) begin
         s_d.dbg = 1'b0;
      end
      if (s_d.dbg && cpu_halted) begin
         s_d.halt_exit = 1'b1;
      end
      s_d.wdt = s_d.dbg && wdt_enabled && !stop_mode;
      case (s_q.st)
         C_CMD: begin
            if (rx_valid) begin
               if (rx_byte == CMD_CRC) begin
                  if (s_q.dbg) begin
                     s_d.crc_start = 1'b1;
                     s_d.pm_rd = 1'b1;
                     s_d.st = C_CRC_WAIT;
                  end else begin
                     s_d.crc = CRC_OFF_VALUE;
                     s_d.st = C_TX_HI;
                  end
               end else if (rx_byte == CMD_STEP) begin
                  if (cmd_ok(s_q.dbg, read_protect)) begin
                     s_d.step = 1'b1;
                     s_d.st = C_RUN;
                  end
               end else if (rx_byte == CMD_STUFF) begin
                  s_d.st = C_STUFF_OP;
               end else if (rx_byte == CMD_EXEC) begin
                  s_d.st = cmd_ok(s_q.dbg, read_protect) ? C_EXEC_BYTES : C_DISCARD;
                  s_d.first = 1'b1;
               end
            end
         end
         C_STUFF_OP: begin
            if (rx_valid) begin
               if (cmd_ok(s_q.dbg, read_protect)) begin
                  s_d.stuff_vld = 1'b1;
                  s_d.stuff_byte = rx_byte;
                  s_d.stuff_first = 1'b1;
                  s_d.st = C_RUN;
               end else begin
                  s_d.st = C_CMD;
               end
            end
         end
         C_EXEC_BYTES: begin
            if (rx_valid) begin
               s_d.stuff_vld = 1'b1;
               s_d.stuff_byte = rx_byte;
               s_d.stuff_first = 1'b0;
               s_d.first = 1'b0;
               if (s_q.first) begin
                  s_d.left = ocdc_op_len(rx_byte) - LEN_ONE;
               end else begin
                  s_d.left = s_q.left - LEN_ONE;
               end
               if ((s_q.first && ocdc_op_len(rx_byte) == LEN_ONE) ||
                   (!s_q.first && s_q.left == LEN_ONE)) begin
                  s_d.st = C_RUN;
               end
            end
         end
         C_DISCARD: begin
            if (rx_valid) begin
               s_d.st = C_CMD;
            end
         end
         C_CRC_WAIT: begin
            if (crc_done) begin
               s_d.crc = crc_val;
               s_d.pm_rd = 1'b0;
               s_d.st = C_TX_HI;
            end
         end
         C_TX_HI: begin
            if (!tx_busy && !s_q.tx_go) begin
               s_d.tx_go = 1'b1;
               s_d.tx_byte = s_q.crc[15:8];
               s_d.st = C_TX_LO;
            end
         end
         C_TX_LO: begin
            if (!tx_busy && !s_q.tx_go) begin
               s_d.tx_go = 1'b1;
               s_d.tx_byte = s_q.crc[7:0];
               s_d.st = C_CMD;
            end
         end
         C_RUN: begin
            if (cpu_instr_done) begin
               s_d.st = C_CMD;
            end
         end
         default: s_d.st = C_CMD;
      endcase
      s_d.fetch_stop = s_d.dbg && (s_d.st != C_RUN);
      s_d.pin_out = tx_out;
      s_d.pin_oe = tx_oe;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '{st: C_CMD, pin_out: 1'b1, rst_prev: 1'b1, key_prev: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // no clock or peripheral gating
   assign shared_debug_pin_out = s_q.pin_out;
   assign shared_debug_pin_oe = s_q.pin_oe;
   assign pm_rd = s_q.pm_rd;
   assign pm_addr = crc_addr;
   assign cpu_fetch_stop = s_q.fetch_stop;
   assign cpu_halt_exit = s_q.halt_exit;
   assign cpu_step = s_q.step;
   assign cpu_stuff_vld = s_q.stuff_vld;
   assign cpu_stuff_byte = s_q.stuff_byte;
   assign cpu_stuff_first = s_q.stuff_first;
   assign wdt_refresh = s_q.wdt;
   assign brk_enabled = s_q.brk_en;
   assign device_reset_req = s_q.dev_rst;
   assign debug_unlocked = s_q.unlocked;
   assign debug_mode = s_q.dbg;
endmodule

//--- rtl/ocdc_uart.sv
/*
 Half-duplex serial engine for the debug wire with autobaud.
 Assumes line idles high, 8N1 bytes, LSB first; first frame is 80h.
*/
`timescale 1ns/100ps
module ocdc_uart
   import ocdc_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic nrst, // Async reset, low
   input wire logic rx_in, // Wire level in
   input wire logic tx_go, // Send request
   input wire logic [7:0] tx_byte, // Byte to send
   output logic rx_valid, // Byte received pulse
   output logic [7:0] rx_byte, // Received byte
   output logic tx_busy, // Not idle: autobaud, receiving or sending
   output logic tx_out, // Wire level out
   output logic tx_oe, // Drive enable
   output logic locked // Baud known
);
   typedef enum logic [2:0] {U_AUTO, U_AUTO_LOW, U_IDLE, U_RX, U_STOP, U_TX} ocdc_u_t;
   typedef struct packed {
      ocdc_u_t st;
      logic [BAUD_W-1:0] baud;
      logic [BAUD_W-1:0] cnt;
      logic [3:0] bitn;
      logic [9:0] sh;
      logic valid;
      logic [7:0] rbyte;
      logic prev;
   } ocdc_u_st_t;

   ocdc_u_st_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.valid = 1'b0;
      s_d.prev = rx_in;
      case (s_q.st)
         U_AUTO: begin
            if (s_q.prev && !rx_in) begin
               s_d.st = U_AUTO_LOW;
               s_d.cnt = BAUD_ONE;
            end
         end
         U_AUTO_LOW: begin
            s_d.cnt = s_q.cnt + BAUD_ONE;
            if (rx_in) begin
               s_d.baud = s_q.cnt >> AUTOBAUD_SHIFT;
               s_d.st = U_IDLE;
            end
         end
         U_IDLE: begin
            if (tx_go) begin
               s_d.st = U_TX;
               s_d.sh = {1'b1, tx_byte, 1'b0};
               s_d.bitn = BIT_ZERO;
               s_d.cnt = BAUD_ZERO;
            end else if (s_q.prev && !rx_in) begin
               s_d.st = U_RX;
               s_d.cnt = s_q.baud >> 1;
               s_d.bitn = BIT_ZERO;
            end
         end
         U_RX: begin
            if (s_q.cnt == s_q.baud - BAUD_ONE) begin
               s_d.cnt = BAUD_ZERO;
               s_d.bitn = s_q.bitn + 1'b1;
               s_d.sh = {rx_in, s_q.sh[9:1]};
               if (s_q.bitn == BITS_FRAME) begin
                  s_d.st = U_STOP;
                  s_d.cnt = s_q.baud >> 1;
                  s_d.valid = 1'b1;
                  s_d.rbyte = s_q.sh[9:2];
               end
            end else begin
               s_d.cnt = s_q.cnt + BAUD_ONE;
            end
         end
         U_STOP: begin
            // Hold off replies until the host stop bit ends
            if (s_q.cnt == s_q.baud - BAUD_ONE) begin
               s_d.st = U_IDLE;
            end else begin
               s_d.cnt = s_q.cnt + BAUD_ONE;
            end
         end
         U_TX: begin
            if (s_q.cnt == s_q.baud - BAUD_ONE) begin
               s_d.cnt = BAUD_ZERO;
               s_d.sh = {1'b1, s_q.sh[9:1]};
               s_d.bitn = s_q.bitn + 1'b1;
               if (s_q.bitn == BITS_FRAME) begin
                  s_d.st = U_IDLE;
               end
            end else begin
               s_d.cnt = s_q.cnt + BAUD_ONE;
            end
         end
         default: s_d.st = U_AUTO;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '{st: U_AUTO, sh: 10'h3ff, prev: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign rx_valid = s_q.valid;
   assign rx_byte = s_q.rbyte;
   assign tx_busy = (s_q.st != U_IDLE);
   assign tx_out = (s_q.st == U_TX) ? s_q.sh[0] : 1'b1;
   assign tx_oe = (s_q.st == U_TX);
   assign locked = (s_q.st != U_AUTO) && (s_q.st != U_AUTO_LOW);
endmodule
